// *** rtl/core_sideband_status.sv ***
// core sideband status: timer request, reservation, identity registers
`timescale 1ns/1ps

module core_sideband_status
  import sideband_pkg::*;
(
  // clock, synchronous reset and clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // timer facility events
  input  wire logic              watchdog_event,
  input  wire logic              decrementer_event,
  output logic                   timer_request,
  // reservation
  input  wire logic              load_reserve,
  input  wire logic              store_cond_done,
  input  wire logic              reservation_clear,
  output logic                   reservation_held,
  // identity and version inputs, held static by the system; process id output and its update strobe
  input  wire logic [CID_W-1:0]  core_id,
  input  wire logic [DATA_W-1:0] system_version,
  input  wire logic [PVL_W-1:0]  processor_version_low,
  output logic [PID_W-1:0]       process_id_out,
  output logic                   process_id_update_strobe,
  // interrupt
  output logic                   irq
);
  // all block state outside the submodules in one word; one comb fill, one register
  typedef struct packed {
    logic             wd_status;
    logic             dec_status;
    logic             wd_enable;
    logic             dec_enable;
    logic             fix_enable;
    logic             timer_request;
    logic [PID_W-1:0] process_id;
    logic             pid_strobe;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic             irq;
  } core_t;

  core_t st;
  core_t next_st;

  // word layout helpers; the package holds the widths, the map, field positions and response codes
  localparam int BYTE_W   = 8;
  localparam int N_LANES  = DATA_W / BYTE_W;
  localparam int RSV_HELD = 0;

  // carrier between the bus front end and the register logic
  reg_access_if bus ();

  // pulses when an external clear drops a held reservation
  logic rsrv_lost;

  // byte-lane merge of a write into a register word
  // lanes with a low strobe keep their old byte
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0]        strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < N_LANES; i++) begin
      if (strb[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_val[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  // register images for the read mux; all but the status image also seed the byte-lane merge
  function automatic logic [DATA_W-1:0] status_image(input core_t s);
    logic [DATA_W-1:0] w;
    w                 = '0;
    w[TS_WATCHDOG]    = s.wd_status;
    w[TS_DECREMENTER] = s.dec_status;
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] control_image(input core_t s);
    logic [DATA_W-1:0] w;
    w                 = '0;
    w[TC_WATCHDOG]    = s.wd_enable;
    w[TC_DECREMENTER] = s.dec_enable;
    w[TC_FIXED_INT]   = s.fix_enable;
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] pid_image(input logic [PID_W-1:0] p);
    logic [DATA_W-1:0] w;
    w            = '0;
    w[PID_W-1:0] = p;
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] irq_image(input logic [IRQ_W-1:0] b);
    logic [DATA_W-1:0] w;
    w            = '0;
    w[IRQ_W-1:0] = b;
    return w;
  endfunction

  // decode of an offset to a mapped register
  // one lookup serves both the write and the read side
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      OFF_TIMER_STATUS,
      OFF_TIMER_CONTROL,
      OFF_PROC_IDENTITY,
      OFF_PROCESS_ID,
      OFF_SYS_VERSION,
      OFF_PROC_VERSION,
      OFF_RESERVATION,
      OFF_IRQ_STATUS,
      OFF_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // bus front end; its answers come from its own flops
  axil_front u_front (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .bus     (bus.front)
  );

  // finished store-conditional arrives as store_cond_done from the bus side
  reservation_tracker u_rsrv (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .reserve_set   (load_reserve),
    .reserve_done  (store_cond_done),
    .reserve_clear (reservation_clear),
    .held          (reservation_held),
    .lost          (rsrv_lost)
  );

  // these four outputs come straight from flops of the state word; reservation_held and the axi outputs come from the submodules
  assign timer_request            = st.timer_request;
  assign process_id_out           = st.process_id;
  assign process_id_update_strobe = st.pid_strobe;
  assign irq                      = st.irq;

  // unmapped offsets answer with an error and change nothing
  assign bus.wr_err = !is_mapped(bus.wr_addr);
  assign bus.rd_err = !is_mapped(bus.rd_addr);

  // read mux; identity inputs are used raw since they never move
  // a read has no side effect here, the status clear sits with the state
  always_comb begin
    bus.rd_data = '0;
    unique case (bus.rd_addr)
      OFF_TIMER_STATUS:  bus.rd_data = status_image(st);
      OFF_TIMER_CONTROL: bus.rd_data = control_image(st);
      OFF_PROC_IDENTITY: bus.rd_data[CID_W-1:0] = core_id;
      OFF_PROCESS_ID:    bus.rd_data = pid_image(st.process_id);
      OFF_SYS_VERSION:   bus.rd_data = system_version;
      OFF_PROC_VERSION:  bus.rd_data = {PVR_UPPER, processor_version_low};
      OFF_RESERVATION:   bus.rd_data[RSV_HELD] = reservation_held;
      OFF_IRQ_STATUS:    bus.rd_data = irq_image(st.irq_status);
      OFF_IRQ_MASK:      bus.rd_data = irq_image(st.irq_mask);
      default:           bus.rd_data = '0;
    endcase
  end

  // register updates; hardware sets always win over software clears
  always_comb begin
    logic [DATA_W-1:0] wv;
    logic [IRQ_W-1:0]  ev;
    wv                 = '0;
    ev                 = '0;
    next_st            = st;
    next_st.pid_strobe = 1'b0;
    // only one write lands per cycle, so a single decode suffices
    if (bus.wr_en) begin
      unique case (bus.wr_addr)
        OFF_TIMER_STATUS: begin
          // write one to clear, only on lanes that carry the bit
          wv = merge_bytes('0, bus.wr_data, bus.wr_strb);
          if (wv[TS_WATCHDOG]) begin
            next_st.wd_status = 1'b0;
          end
          if (wv[TS_DECREMENTER]) begin
            next_st.dec_status = 1'b0;
          end
        end
        OFF_TIMER_CONTROL: begin
          wv = merge_bytes(control_image(st), bus.wr_data, bus.wr_strb);
          next_st.wd_enable  = wv[TC_WATCHDOG];
          next_st.dec_enable = wv[TC_DECREMENTER];
          next_st.fix_enable = wv[TC_FIXED_INT];
        end
        OFF_PROCESS_ID: begin
          // a rewrite of the same value still strobes
          wv = merge_bytes(pid_image(st.process_id), bus.wr_data, bus.wr_strb);
          next_st.process_id = wv[PID_W-1:0];
          // strobe flop loads on the same edge as the outputs
          next_st.pid_strobe = 1'b1;
        end
        OFF_IRQ_MASK: begin
          wv = merge_bytes(irq_image(st.irq_mask), bus.wr_data, bus.wr_strb);
          next_st.irq_mask = wv[IRQ_W-1:0];
        end
        default: begin
          wv = '0;
        end
      endcase
    end
    // timer unit events are sticky
    // placed after the write decode so an event beats a same-cycle clear
    if (watchdog_event) begin
      next_st.wd_status = 1'b1;
    end
    if (decrementer_event) begin
      next_st.dec_status = 1'b1;
    end
    // request follows the new register values so it moves with them
    // fixed-interval enable alone raises it, no status bit needed
    next_st.timer_request = (next_st.wd_status && next_st.wd_enable)
                         || (next_st.dec_status && next_st.dec_enable)
                         || next_st.fix_enable;
    // event collection for the interrupt status
    // b1 counts only clears from outside, not a finished store-conditional
    ev[EV_TIMER]      = next_st.timer_request && !st.timer_request;
    ev[EV_RSRV_LOST]  = rsrv_lost;
    ev[EV_PID_UPDATE] = next_st.pid_strobe;
    // read clears status, a same-cycle event survives the clear
    if (bus.rd_en && bus.rd_addr == OFF_IRQ_STATUS) begin
      next_st.irq_status = ev;
    end else begin
      next_st.irq_status = st.irq_status | ev;
    end
    // level interrupt; masking leaves the sticky status untouched
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // all control state clears on reset; ce low freezes everything
  // reset is tested first, so a frozen block can still be reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

// *** rtl/sideband_pkg.sv ***
// constants shared by the sideband status block
package sideband_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PID_W  = 8;
  localparam int CID_W  = 8;
  localparam int PVL_W  = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TIMER_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PROC_IDENTITY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PROCESS_ID    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SYS_VERSION   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PROC_VERSION  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RESERVATION   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK      = 8'h20;

  // field positions
  localparam int TS_WATCHDOG    = 0;
  localparam int TS_DECREMENTER = 1;
  localparam int TC_WATCHDOG    = 0;
  localparam int TC_DECREMENTER = 1;
  localparam int TC_FIXED_INT   = 2;
  localparam int IRQ_W          = 3;
  localparam int EV_TIMER       = 0;
  localparam int EV_RSRV_LOST   = 1;
  localparam int EV_PID_UPDATE  = 2;

  // upper half of the processor version word; value is arbitrary
  localparam logic [PVL_W-1:0] PVR_UPPER = 16'h0A5C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/reg_access_if.sv ***
// register access carrier between the bus front end and the block core
`timescale 1ns/1ps
interface reg_access_if;
  import sideband_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;

  modport front (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input  wr_err, rd_data, rd_err);
  modport core  (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface

// *** rtl/axil_front.sv ***
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module axil_front
  import sideband_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  reg_access_if.front            bus
);
  typedef struct packed {
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdat;
    logic [3:0]        wstb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } front_t;

  front_t st;
  front_t next_st;

  // the write is issued once both halves sit here and no answer is pending
  assign bus.wr_en   = ce && st.aw_got && st.w_got && !st.bvalid;
  assign bus.wr_addr = st.waddr;
  assign bus.wr_data = st.wdat;
  assign bus.wr_strb = st.wstb;
  assign bus.rd_en   = ce && arvalid && st.arready;
  assign bus.rd_addr = araddr;

  assign awready = st.awready;
  assign wready  = st.wready;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arready;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;

  // address and data are taken in either order
  always_comb begin
    next_st = st;
    if (awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr  = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdat  = wdata;
      next_st.wstb  = wstrb;
    end
    if (bus.wr_en) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = bus.wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (bus.rd_en) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = bus.rd_data;
      next_st.rresp  = bus.rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // ready flags are registered so each output comes from a flop
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

// *** rtl/reservation_tracker.sv ***
// holds the load-reserve reservation flag
`timescale 1ns/1ps
module reservation_tracker (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic reserve_set,
  input  wire logic reserve_done,
  input  wire logic reserve_clear,
  output logic      held,
  output logic      lost
);
  typedef struct packed {
    logic held;
    logic lost;
  } rsrv_t;

  rsrv_t st;
  rsrv_t next_st;

  assign held = st.held;
  assign lost = st.lost;

  // external clear has top priority and ignores any bus activity
  always_comb begin
    next_st      = st;
    next_st.lost = 1'b0;
    if (reserve_clear) begin
      next_st.held = 1'b0;
      next_st.lost = st.held;
    end else if (reserve_done) begin
      next_st.held = 1'b0;
    end else if (reserve_set) begin
      next_st.held = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

// *** sim/sideband_properties.sv ***
// port-level checks for the sideband status block
`timescale 1ns/1ps
module sideband_properties
  import sideband_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              watchdog_event,
  input wire logic              decrementer_event,
  input wire logic              timer_request,
  input wire logic              load_reserve,
  input wire logic              store_cond_done,
  input wire logic              reservation_clear,
  input wire logic              reservation_held,
  input wire logic [CID_W-1:0]  core_id,
  input wire logic [DATA_W-1:0] system_version,
  input wire logic [PVL_W-1:0]  processor_version_low,
  input wire logic [PID_W-1:0]  process_id_out,
  input wire logic              process_id_update_strobe
);
  // a frozen clock enable holds all state, so checks pause with it
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // read request taken at a given offset
  sequence ar_taken(off);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == off;
  endsequence

  // timer request only rises on an event or a completed write
  property p_tmr;
    $rose(timer_request) |-> $past(watchdog_event || decrementer_event) || $rose(s_axi_bvalid);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer request rose without cause");
  property p_rsv_set;
    load_reserve && !reservation_clear && !store_cond_done |=> reservation_held;
  endproperty
  a_rsv_set: assert property (p_rsv_set) else $error("reservation not held");
  property p_rsv_clr;
    reservation_clear |=> !reservation_held;
  endproperty
  a_rsv_clr: assert property (p_rsv_clr) else $error("reservation survived clear");
  property p_pid_strb;
    process_id_out != $past(process_id_out) |-> process_id_update_strobe;
  endproperty
  a_pid_strb: assert property (p_pid_strb) else $error("process id moved without strobe");
  property p_rd_cid;
    ar_taken(OFF_PROC_IDENTITY) |=> s_axi_rvalid && s_axi_rdata == {24'h000000, core_id};
  endproperty
  a_rd_cid: assert property (p_rd_cid) else $error("identity read wrong");
  property p_rd_sys;
    ar_taken(OFF_SYS_VERSION) |=> s_axi_rvalid && s_axi_rdata == system_version;
  endproperty
  a_rd_sys: assert property (p_rd_sys) else $error("system version read wrong");
  property p_rd_pvr;
    ar_taken(OFF_PROC_VERSION) |=> s_axi_rvalid && s_axi_rdata == {PVR_UPPER, processor_version_low};
  endproperty
  a_rd_pvr: assert property (p_rd_pvr) else $error("processor version read wrong");
  property p_rd_pid;
    ar_taken(OFF_PROCESS_ID) |=> s_axi_rdata[PID_W-1:0] == process_id_out;
  endproperty
  a_rd_pid: assert property (p_rd_pid) else $error("process id read differs from pins");

  // main scenarios reached
  c_tmr: cover property ($rose(timer_request));
  c_rsv: cover property (reservation_held ##1 !reservation_held);
  c_pid: cover property (process_id_update_strobe);
endmodule

bind core_sideband_status sideband_properties chk_u (.aclk, .aresetn, .ce, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .watchdog_event, .decrementer_event,
  .timer_request, .load_reserve, .store_cond_done, .reservation_clear, .reservation_held, .core_id,
  .system_version, .processor_version_low, .process_id_out, .process_id_update_strobe);

// *** sim/system_partner.sv ***
// system-side model: static identity inputs and a wake latch
`timescale 1ns/1ps
module system_partner
  import sideband_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         timer_request,
  output logic [CID_W-1:0]  core_id,
  output logic [DATA_W-1:0] system_version,
  output logic [PVL_W-1:0]  processor_version_low,
  output logic              wake
);
  // values are arbitrary; they never move since the block does not resync them
  assign core_id = 8'h3C;
  assign system_version = 32'h5E17A0B3;
  assign processor_version_low = 16'h7E51;

  // leaves low power on the timer request and stays awake
  always_ff @(posedge aclk) begin
    if (!aresetn) wake <= 1'b0;
    else if (timer_request) wake <= 1'b1;
  end
endmodule

// *** sim/tb.sv ***
// self-checking bench for the sideband status block
`timescale 1ns/1ps
module tb;
  import sideband_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd, system_version;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              watchdog_event = 1'b0, decrementer_event = 1'b0, load_reserve = 1'b0;
  logic              store_cond_done = 1'b0, reservation_clear = 1'b0;
  logic              timer_request, reservation_held, process_id_update_strobe, irq, wake;
  logic [CID_W-1:0]  core_id;
  logic [PVL_W-1:0]  processor_version_low;
  logic [PID_W-1:0]  process_id_out;
  int                miscompares = 0, n_tests = 0, n_strobe = 0;

  core_sideband_status dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .watchdog_event, .decrementer_event, .timer_request, .load_reserve, .store_cond_done,
    .reservation_clear, .reservation_held, .core_id, .system_version, .processor_version_low,
    .process_id_out, .process_id_update_strobe, .irq);
  system_partner sys_u (.aclk, .aresetn, .timer_request, .core_id, .system_version,
    .processor_version_low, .wake);

  always #2 aclk = ~aclk;
  // strobe counter; a stuck or missing strobe shows in the count
  always @(posedge aclk) if (process_id_update_strobe === 1'b1) n_strobe <= n_strobe + 1;

  task automatic complete_run();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    miscompares++;
    $display("MISMATCH t=%0t wait ran out", $time);
    complete_run();
  endtask
  // both write halves offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) timed_out();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) timed_out();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle pulse: 0 watchdog, 1 decrementer, 2 reserve, 3 store-cond end, 4 clear
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: watchdog_event <= 1'b1;
      1: decrementer_event <= 1'b1;
      2: load_reserve <= 1'b1;
      3: store_cond_done <= 1'b1;
      default: reservation_clear <= 1'b1;
    endcase
    @(posedge aclk);
    {watchdog_event, decrementer_event, load_reserve, store_cond_done, reservation_clear} <= 5'h00;
    repeat (2) @(posedge aclk);
  endtask

  task automatic s_identity();
    axi_read(OFF_PROC_IDENTITY);
    check(rd, {24'h000000, core_id});
    axi_read(OFF_SYS_VERSION);
    check(rd, system_version);
    axi_read(OFF_PROC_VERSION);
    check(rd, {PVR_UPPER, processor_version_low});
    axi_read(8'h40);
    check(rd, 32'h00000000);
    check(rsp, RESP_SLVERR);
    axi_write(8'h40, 32'hFFFFFFFF);
    check(rsp, RESP_SLVERR);
  endtask
  // the repeated value must strobe again
  task automatic s_process_id();
    logic [7:0] v[3];
    int c;
    v = '{8'h5A, 8'h5A, 8'hC3};
    foreach (v[i]) begin
      c = n_strobe;
      axi_write(OFF_PROCESS_ID, {24'h000000, v[i]});
      check(rsp, RESP_OKAY);
      @(posedge aclk);
      check(process_id_out, v[i]);
      check(n_strobe - c, 1);
      axi_read(OFF_PROCESS_ID);
      check(rd, {24'h000000, v[i]});
    end
  endtask
  task automatic s_timer();
    axi_write(OFF_TIMER_CONTROL, 32'h0);
    axi_write(OFF_TIMER_STATUS, 32'h3);
    pulse(0);
    check(timer_request, 1'b0);
    axi_write(OFF_TIMER_CONTROL, 32'h1);
    check(timer_request, 1'b1);
    // the partner latches the request one edge after it rises
    @(posedge aclk);
    check(wake, 1'b1);
    axi_write(OFF_TIMER_STATUS, 32'h1);
    check(timer_request, 1'b0);
    axi_write(OFF_TIMER_CONTROL, 32'h2);
    pulse(1);
    check(timer_request, 1'b1);
    axi_write(OFF_TIMER_STATUS, 32'h2);
    check(timer_request, 1'b0);
    axi_write(OFF_TIMER_CONTROL, 32'h4);
    check(timer_request, 1'b1);
    axi_write(OFF_TIMER_CONTROL, 32'h0);
    check(timer_request, 1'b0);
  endtask
  // ce low freezes all state, so a reserve pulse meanwhile is lost
  task automatic s_freeze();
    @(posedge aclk);
    ce <= 1'b0;
    pulse(2);
    check(reservation_held, 1'b0);
    @(posedge aclk);
    ce <= 1'b1;
  endtask
  // the clear lands while a read is in flight; its event shows only once unmasked
  task automatic s_rsrv_irq();
    axi_write(OFF_IRQ_MASK, 32'h0);
    axi_read(OFF_IRQ_STATUS);
    pulse(2);
    check(reservation_held, 1'b1);
    axi_read(OFF_RESERVATION);
    check(rd, 32'h1);
    pulse(3);
    check(reservation_held, 1'b0);
    pulse(2);
    fork
      pulse(4);
      axi_read(OFF_TIMER_CONTROL);
    join
    check(reservation_held, 1'b0);
    check(irq, 1'b0);
    axi_write(OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    axi_read(OFF_IRQ_STATUS);
    check(rd & 32'h2, 32'h2);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_identity();
    s_process_id();
    s_timer();
    s_freeze();
    s_rsrv_irq();
    complete_run();
  end
endmodule
